// file: rtl/pic_consts.svh
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
// Oscillator and derived rates, in kHz.
`define PIC_OSC_KHZ 50000
`define PIC_BASIC_KHZ 1024
// Time pulses in one memory cycle.
`define PIC_TP_NUM 12
// Real-time count period in ms and count periods per second.
`define PIC_RT_TICK_MS 10
`define PIC_TICKS_PER_S 100
// Fastest timer period in us.
`define PIC_T6_TICK_US 625
// Source counts and widths.
`define PIC_NUM_RUPT 10
`define PIC_NUM_CNT 29
`define PIC_RT_W 28
// Counter indices and interrupt bit positions.
`define PIC_RT_CNT_IDX 0
`define PIC_UPL_CNT_IDX 1
`define PIC_IRQ_KEY 4
`define PIC_IRQ_HAND 9
// Addresses sent to the central processor.
`define PIC_CNT_BASE 12'h020
`define PIC_RUPT_BASE 12'h800
`endif

// file: rtl/pic_pkg.sv
package pic_pkg;
	typedef enum logic [1:0] {PIC_ORD_NONE, PIC_ORD_COUNT, PIC_ORD_RUPT, PIC_ORD_RESUME} pic_ord_t;
	typedef enum logic {PIC_PROG, PIC_RUPT} pic_mode_t;

	typedef struct packed {
		logic [15:0] acc;
		logic        basic_en;
		logic        sync;
		logic [11:0] tp;
		logic        mcs;
		logic [13:0] scl;
		logic [9:0]  t6c;
		logic [6:0]  sec;
		logic [4:0]  tick;
	} pic_tmr_st_t;

	typedef struct packed {
		logic [28:0] pend;
		logic        alarm;
	} pic_arb_st_t;

	typedef struct packed {
		pic_mode_t        mode;
		logic             ret_pend;
		logic [9:0]       pend;
		logic             hand_prev;
		logic             ord_valid;
		pic_ord_t         ord;
		logic [11:0]      addr;
		logic [27:0]      rt;
		logic             dn_valid;
		logic [27:0]      dn_time;
		logic [4:0]       key;
		logic [15:0]      disc;
		logic [2:0][14:0] bcnt;
		logic [2:0][9:0]  btmr;
		logic [2:0][9:0]  bgap;
		logic [2:0]       bout;
	} pic_top_st_t;

	// Index of the lowest set bit, which is the highest rank; 5'h1F when none.
	function automatic logic [4:0] pic_first(input logic [31:0] v);
		pic_first = 5'h1F;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				pic_first = 5'(i);
			end
		end
	endfunction
endpackage

// file: rtl/pic_timer.sv
`include "pic_consts.svh"
module pic_timer #(
	parameter logic [13:0] RT_TICK_BASIC = 14'(`PIC_BASIC_KHZ * `PIC_RT_TICK_MS)
) (
	input  wire logic        clk,             // System clock.
	input  wire logic        rst_n,           // Synchronous reset, low.
	output logic             basic_en,        // One pulse per basic clock period.
	output logic             sync_out,        // Continuous sync square wave.
	output logic [11:0]      time_pulse,      // One-hot time pulse.
	output logic             mem_cycle_start, // First time pulse of a memory cycle.
	output logic [4:0]       tick             // {sec, t4, t3, t5, t6} pulses.
);
	localparam logic [15:0] STEP = 16'(`PIC_BASIC_KHZ);
	localparam logic [15:0] WRAP = 16'(`PIC_OSC_KHZ);
	localparam logic [9:0]  T6_BASIC = 10'(`PIC_BASIC_KHZ * `PIC_T6_TICK_US / 1000);
	localparam logic [6:0]  SEC_TICKS = 7'(`PIC_TICKS_PER_S);

	pic_pkg::pic_tmr_st_t st_ff;
	pic_pkg::pic_tmr_st_t nxt_st;

	// A phase accumulator gives the exact average basic rate from a non-integer ratio.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.basic_en = 1'b0;
		nxt_st.mcs = 1'b0;
		nxt_st.tick = 5'h00;
		if (st_ff.acc + STEP >= WRAP) begin // R16
			nxt_st.acc = 16'(st_ff.acc + STEP - WRAP);
			nxt_st.basic_en = 1'b1;
		end else begin
			nxt_st.acc = 16'(st_ff.acc + STEP);
		end
		nxt_st.sync = nxt_st.acc >= (WRAP >> 1); // R12
		if (st_ff.basic_en) begin
			nxt_st.tp = {st_ff.tp[10:0], st_ff.tp[11]}; // R18 R21
			nxt_st.mcs = st_ff.tp[11];
			nxt_st.t6c = (st_ff.t6c == T6_BASIC - 10'h001) ? 10'h000 : 10'(st_ff.t6c + 10'h001);
			nxt_st.tick[0] = (st_ff.t6c == 10'h000);
			nxt_st.scl = (st_ff.scl == RT_TICK_BASIC - 14'h0001) ? 14'h0000 : 14'(st_ff.scl + 14'h0001); // R17
			nxt_st.tick[1] = (st_ff.scl == 14'h0000);
			nxt_st.tick[2] = (st_ff.scl == (RT_TICK_BASIC >> 1));
			nxt_st.tick[3] = (st_ff.scl == (RT_TICK_BASIC >> 2));
			if (st_ff.scl == 14'h0000) begin
				nxt_st.sec = (st_ff.sec == SEC_TICKS - 7'h01) ? 7'h00 : 7'(st_ff.sec + 7'h01);
				nxt_st.tick[4] = (st_ff.sec == 7'h00);
			end
		end
	end

	// Register the timer state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.tp <= 12'h001;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign basic_en = st_ff.basic_en;
	assign sync_out = st_ff.sync;
	assign time_pulse = st_ff.tp;
	assign mem_cycle_start = st_ff.mcs;
	assign tick = st_ff.tick;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_gap;
		!basic_en [*8];
	endsequence
	property p_basic_gap;
		basic_en |=> s_gap;
	endproperty
	a_basic_gap: assert property (p_basic_gap) else $error("basic pulses too close"); // R16

	property p_cycle_wrap;
		basic_en && time_pulse[11] |=> mem_cycle_start && time_pulse == 12'h001;
	endproperty
	a_cycle_wrap: assert property (p_cycle_wrap) else $error("memory cycle did not wrap"); // R21
endmodule // pic_timer

// file: rtl/pic_cnt_arb.sv
`include "pic_consts.svh"
module pic_cnt_arb (
	input  wire logic        clk,   // System clock.
	input  wire logic        rst_n, // Synchronous reset, low.
	input  wire logic [28:0] req,   // Incremental pulses, one per counter.
	input  wire logic        take,  // Grant of the top pending counter.
	output logic             any,   // A counter request is pending.
	output logic [4:0]       idx,   // Top-ranked pending counter.
	output logic             alarm  // Pulse arrived before its last was served.
);
	pic_pkg::pic_arb_st_t st_ff;
	pic_pkg::pic_arb_st_t nxt_st;
	logic [28:0]          clr;

	assign any = |st_ff.pend;
	assign idx = pic_pkg::pic_first({3'b000, st_ff.pend});
	assign clr = take ? (29'h0000001 << idx) : 29'h0000000;

	// A new pulse wins over the grant that clears its bit in the same cycle.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pend = (st_ff.pend & ~clr) | req; // R8 R22
		nxt_st.alarm = |(req & st_ff.pend & ~clr); // R20
	end

	// Register the pending set.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign alarm = st_ff.alarm;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_overrun;
		|(req & st_ff.pend & ~clr) |=> alarm;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R20

	property p_hold;
		any && !take |=> any;
	endproperty
	a_hold: assert property (p_hold) else $error("pending counter lost"); // R22
endmodule // pic_cnt_arb

// file: rtl/pic_top.sv
// Notes on behaviour
// R1: Counter servicing ranks first and merely delays whatever was running.
// R2: A program interrupt suspends the program but never another service.
// R3: A software inhibit keeps program interrupts from preempting the program.
// R4: Ten interrupts rank timer 6, 5, 3, 4, key, mark, uplink, downlink, radar, hand.
// R5: Timers are internal; others come from keys, mark, uplink, downlink, radar, controller.
// R6: Interrupt entry is an order code to the sequencer with the routine address.
// R7: Routine return resumes the program only if no other interrupt waits or the software inhibit is set.
// R8: Each incremental pulse yields a counter address and a request.
// R9: Timer pulses advance a 28-bit real-time count spanning 745.65 hours.
// R10: The real-time count goes out on the downlink once a second.
// R11: Output channels issue software-sized pulse bursts and discrete outputs.
// R12: A continuous 1.024 MHz sync pulse train is driven out.
// R13: Each uplink bit requests the uplink counter for serial shifting.
// R14: Downlink timing is supplied by the instrumentation side, asynchronously.
// R15: A key press latches its code and requests the key routine.
// R16: The oscillator is divided to the 1,024 kpps basic clock.
// R17: A scaler divides the basic clock further for timekeeping ticks.
// R18: A repeating set of time pulses defines each memory cycle.
// R19: Order codes are presented at the end of each instruction.
// R20: Twenty-nine counters are ranked; an unserved pulse raises an alarm.
// R21: Twelve time pulses recur in every memory cycle.
// R22: Requests wait for the next instruction boundary; the top rank wins.
`include "pic_consts.svh"
module pic_top #(
	parameter logic [13:0] RT_TICK_BASIC = 14'(`PIC_BASIC_KHZ * `PIC_RT_TICK_MS)
) (
	input  wire logic        clk,               // System clock, 50 MHz.
	input  wire logic        rst_n,             // Synchronous reset, low.
	input  wire logic        instr_end,         // Sequencer instruction boundary.
	input  wire logic        rupt_return,       // Boundary ends a service routine.
	input  wire logic        rupt_inhibit,      // Software interrupt inhibit.
	output logic             ord_valid,         // Order code strobe.
	output pic_pkg::pic_ord_t ord_code,         // Order code to the sequencer.
	output logic [11:0]      ord_addr,          // Address for the write lines.
	output logic             in_rupt,           // A service routine is running.
	input  wire logic [26:0] inc_pulse,         // External incremental pulses.
	input  wire logic        uplink_bit,        // One uplink bit received.
	input  wire logic        uplink_word_done,  // Uplink word complete.
	input  wire logic        key_press,         // Keyboard press strobe.
	input  wire logic [4:0]  key_code,          // Code of the pressed key.
	input  wire logic        mark_in,           // Sighting mark discrete.
	input  wire logic        radar_word_done,   // Radar word complete.
	input  wire logic        hand_in_detent,    // Hand controller in detent.
	input  wire logic        dnlink_word_req,   // Downlink wants a word.
	input  wire logic [2:0]  burst_load,        // Load one burst channel.
	input  wire logic [14:0] burst_num,         // Pulses in the burst.
	input  wire logic [9:0]  burst_gap,         // Basic periods between pulses.
	output logic [2:0]       burst_out,         // Burst pulses.
	input  wire logic        disc_we,           // Discrete channel write.
	input  wire logic [15:0] disc_data,         // Discrete channel data.
	output logic [15:0]      disc_out,          // Discrete outputs.
	output logic [4:0]       key_chan,          // Latched key code channel.
	output logic             count_alarm,       // Counter overrun alarm.
	output logic             sync_out,          // Sync pulse train.
	output logic [11:0]      time_pulse,        // One-hot time pulses.
	output logic             mem_cycle_start,   // Memory cycle start.
	output logic             dnlink_time_valid, // Real-time word strobe.
	output logic [27:0]      dnlink_time        // Real-time word.
);
	localparam logic [4:0] RT_IDX = 5'(`PIC_RT_CNT_IDX);
	localparam logic [4:0] NONE = 5'h1F;

	pic_pkg::pic_top_st_t st_ff;
	pic_pkg::pic_top_st_t nxt_st;
	logic                 basic_en;
	logic [4:0]           tick;
	logic [28:0]          cnt_req;
	logic                 cnt_any;
	logic [4:0]           cnt_idx;
	logic                 cnt_take;
	logic [9:0]           rupt_set;
	logic [9:0]           rupt_clr;
	logic [4:0]           rupt_idx;

	// Clock division, scaler and time pulses.
	pic_timer #(
		.RT_TICK_BASIC(RT_TICK_BASIC)
	) u_timer (
		.clk            (clk),
		.rst_n          (rst_n),
		.basic_en       (basic_en),
		.sync_out       (sync_out),
		.time_pulse     (time_pulse),
		.mem_cycle_start(mem_cycle_start),
		.tick           (tick)
	);

	// The real-time tick and uplink bits are counters like the external pulses.
	assign cnt_req = {inc_pulse, uplink_bit, tick[1]}; // R8 R9 R13
	assign cnt_take = instr_end && cnt_any; // R1 R20

	// Counter ranking and overrun detection.
	pic_cnt_arb u_arb (
		.clk  (clk),
		.rst_n(rst_n),
		.req  (cnt_req),
		.take (cnt_take),
		.any  (cnt_any),
		.idx  (cnt_idx),
		.alarm(count_alarm)
	);

	// Interrupt sources; bit 0 ranks highest.
	always_comb begin
		rupt_set = 10'h000;
		rupt_set[0] = tick[0]; // R5
		rupt_set[1] = tick[1];
		rupt_set[2] = tick[2];
		rupt_set[3] = tick[3];
		rupt_set[4] = key_press; // R15
		rupt_set[5] = mark_in;
		rupt_set[6] = uplink_word_done;
		rupt_set[7] = dnlink_word_req; // R14
		rupt_set[8] = radar_word_done;
		rupt_set[9] = st_ff.hand_prev && !hand_in_detent;
	end

	assign rupt_idx = pic_pkg::pic_first({22'h000000, st_ff.pend}); // R4

	// Boundary arbitration: counters, then return or chaining, then entry.
	always_comb begin
		nxt_st = st_ff;
		rupt_clr = 10'h000;
		nxt_st.ord_valid = 1'b0;
		nxt_st.dn_valid = 1'b0;
		nxt_st.hand_prev = hand_in_detent;
		if (rupt_return && !cnt_take) begin
			nxt_st.ret_pend = 1'b0;
		end else if (rupt_return) begin
			nxt_st.ret_pend = 1'b1;
		end
		if (instr_end) begin // R19 R22
			if (cnt_any) begin // R1
				nxt_st.ord_valid = 1'b1;
				nxt_st.ord = pic_pkg::PIC_ORD_COUNT;
				nxt_st.addr = 12'(`PIC_CNT_BASE + {7'h00, cnt_idx}); // R8
				if (cnt_idx == RT_IDX) begin
					nxt_st.rt = 28'(st_ff.rt + 28'h0000001); // R9
				end
			end else begin
				unique case (st_ff.mode)
					pic_pkg::PIC_RUPT: begin
						// A running routine is never preempted by another interrupt.
						if (rupt_return || st_ff.ret_pend) begin // R2
							nxt_st.ret_pend = 1'b0;
							nxt_st.ord_valid = 1'b1;
							if (rupt_idx != NONE && !rupt_inhibit) begin // R7
								nxt_st.ord = pic_pkg::PIC_ORD_RUPT;
								nxt_st.addr = 12'(`PIC_RUPT_BASE + {5'h00, rupt_idx, 2'b00});
								rupt_clr[rupt_idx[3:0]] = 1'b1;
							end else begin
								nxt_st.ord = pic_pkg::PIC_ORD_RESUME;
								nxt_st.addr = 12'h000;
								nxt_st.mode = pic_pkg::PIC_PROG;
							end
						end
					end
					pic_pkg::PIC_PROG: begin
						if (rupt_idx != NONE && !rupt_inhibit) begin // R2 R3
							nxt_st.ord_valid = 1'b1;
							nxt_st.ord = pic_pkg::PIC_ORD_RUPT; // R6
							nxt_st.addr = 12'(`PIC_RUPT_BASE + {5'h00, rupt_idx, 2'b00});
							nxt_st.mode = pic_pkg::PIC_RUPT;
							rupt_clr[rupt_idx[3:0]] = 1'b1;
						end
					end
				endcase
			end
		end
		// A source that fires in the cycle of its grant stays pending.
		nxt_st.pend = (st_ff.pend & ~rupt_clr) | rupt_set;
		if (tick[4]) begin // R10
			nxt_st.dn_valid = 1'b1;
			nxt_st.dn_time = st_ff.rt;
		end
		if (key_press) begin // R15
			nxt_st.key = key_code;
		end
		if (disc_we) begin // R11
			nxt_st.disc = disc_data;
		end
		// Bursts pace on the basic clock, so the gap resolution is one basic period.
		for (int c = 0; c < 3; c++) begin
			nxt_st.bout[c] = 1'b0;
			if (burst_load[c]) begin // R11
				nxt_st.bcnt[c] = burst_num;
				nxt_st.bgap[c] = burst_gap;
				nxt_st.btmr[c] = 10'h000;
			end else if (basic_en && st_ff.bcnt[c] != 15'h0000) begin
				if (st_ff.btmr[c] == 10'h000) begin
					nxt_st.bout[c] = 1'b1;
					nxt_st.bcnt[c] = 15'(st_ff.bcnt[c] - 15'h0001);
					nxt_st.btmr[c] = st_ff.bgap[c];
				end else begin
					nxt_st.btmr[c] = 10'(st_ff.btmr[c] - 10'h001);
				end
			end
		end
	end

	// Register the whole controller state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ord_valid = st_ff.ord_valid;
	assign ord_code = st_ff.ord;
	assign ord_addr = st_ff.addr;
	assign in_rupt = (st_ff.mode == pic_pkg::PIC_RUPT);
	assign burst_out = st_ff.bout;
	assign disc_out = st_ff.disc;
	assign key_chan = st_ff.key;
	assign dnlink_time_valid = st_ff.dn_valid;
	assign dnlink_time = st_ff.dn_time;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_cnt_first;
		instr_end && cnt_any |=> ord_valid && ord_code == pic_pkg::PIC_ORD_COUNT;
	endproperty
	a_cnt_first: assert property (p_cnt_first) else $error("counter not served first"); // R1

	property p_no_nest;
		instr_end && !cnt_any && in_rupt && !rupt_return && !st_ff.ret_pend |=> !ord_valid;
	endproperty
	a_no_nest: assert property (p_no_nest) else $error("routine was preempted"); // R2

	property p_inhibit;
		instr_end && !cnt_any && !in_rupt && rupt_inhibit |=> !ord_valid && !in_rupt;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit ignored"); // R3

	sequence s_lone_return;
		instr_end && rupt_return && in_rupt && !cnt_any && st_ff.pend == 10'h000;
	endsequence
	property p_resume;
		s_lone_return |=> ord_valid && ord_code == pic_pkg::PIC_ORD_RESUME && !in_rupt;
	endproperty
	a_resume: assert property (p_resume) else $error("return did not resume"); // R7

	property p_entry_addr;
		ord_valid && ord_code == pic_pkg::PIC_ORD_RUPT |-> ord_addr[11:6] == 6'h20 && in_rupt;
	endproperty
	a_entry_addr: assert property (p_entry_addr) else $error("bad entry"); // R6

	property p_rt_step;
		instr_end && cnt_any && cnt_idx == RT_IDX |=> st_ff.rt == 28'($past(st_ff.rt) + 28'h1);
	endproperty
	a_rt_step: assert property (p_rt_step) else $error("real time not advanced"); // R9

	property p_dn_time;
		tick[4] |=> dnlink_time_valid && dnlink_time == $past(st_ff.rt);
	endproperty
	a_dn_time: assert property (p_dn_time) else $error("downlink time wrong"); // R10

	property p_key;
		key_press |=> key_chan == $past(key_code) && st_ff.pend[`PIC_IRQ_KEY];
	endproperty
	a_key: assert property (p_key) else $error("key not latched"); // R15

	property p_hand;
		$fell(hand_in_detent) |=> st_ff.pend[`PIC_IRQ_HAND];
	endproperty
	a_hand: assert property (p_hand) else $error("detent exit missed"); // R5
endmodule // pic_top

// file: verif/pic_seq_model.sv
module pic_seq_model (
	input  wire logic              clk,             // System clock.
	input  wire logic              ord_valid,       // Order code strobe.
	input  wire pic_pkg::pic_ord_t ord_code,        // Order code.
	input  wire logic [11:0]       ord_addr,        // Counter or routine address.
	output logic                   instr_end,       // Instruction boundary pulse.
	output logic                   rupt_return,     // Boundary closes a routine.
	output logic                   dnlink_word_req  // Downlink asks for a word.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle sequencer: no boundary and no downlink request.
	initial begin
		instr_end = 1'b0;
		rupt_return = 1'b0;
		dnlink_word_req = 1'b0;
	end

	// One boundary, then three cycles to collect the order; a late answer still counts once.
	task automatic boundary(input logic ret, output logic got, output pic_pkg::pic_ord_t code,
		output logic [11:0] addr);
		got = 1'b0;
		code = pic_pkg::PIC_ORD_NONE;
		addr = 12'h000;
		@(negedge clk);
		instr_end = 1'b1;
		rupt_return = ret;
		@(negedge clk);
		instr_end = 1'b0;
		rupt_return = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (ord_valid === 1'b1 && got === 1'b0) begin
				got = 1'b1;
				code = ord_code;
				addr = ord_addr;
			end
			@(negedge clk);
		end
	endtask

	// The downlink side paces its own word requests.
	task automatic dn_req();
		@(negedge clk);
		dnlink_word_req = 1'b1;
		@(negedge clk);
		dnlink_word_req = 1'b0;
	endtask
endmodule // pic_seq_model

// file: verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, instr_end, rupt_return, rupt_inhibit, ord_valid, in_rupt;
	logic uplink_bit, uplink_word_done, key_press, mark_in, radar_word_done;
	logic hand_in_detent, dnlink_word_req, disc_we, count_alarm, sync_out;
	logic mem_cycle_start, dnlink_time_valid;
	pic_pkg::pic_ord_t ord_code, code;
	logic [11:0] ord_addr, addr, time_pulse;
	logic [26:0] inc_pulse;
	logic [4:0]  key_code, key_chan;
	logic [2:0]  burst_load, burst_out;
	logic [14:0] burst_num;
	logic [9:0]  burst_gap;
	logic [15:0] disc_data, disc_out;
	logic [27:0] dnlink_time;
	logic        got;
	int          n_mismatch, tests_run, cyc;

	pic_top pic_top_i (.clk(clk), .rst_n(rst_n), .instr_end(instr_end), .rupt_return(rupt_return),
		.rupt_inhibit(rupt_inhibit), .ord_valid(ord_valid), .ord_code(ord_code),
		.ord_addr(ord_addr), .in_rupt(in_rupt), .inc_pulse(inc_pulse), .uplink_bit(uplink_bit),
		.uplink_word_done(uplink_word_done), .key_press(key_press), .key_code(key_code),
		.mark_in(mark_in), .radar_word_done(radar_word_done), .hand_in_detent(hand_in_detent),
		.dnlink_word_req(dnlink_word_req), .burst_load(burst_load), .burst_num(burst_num),
		.burst_gap(burst_gap), .burst_out(burst_out), .disc_we(disc_we), .disc_data(disc_data),
		.disc_out(disc_out), .key_chan(key_chan), .count_alarm(count_alarm),
		.sync_out(sync_out), .time_pulse(time_pulse), .mem_cycle_start(mem_cycle_start),
		.dnlink_time_valid(dnlink_time_valid), .dnlink_time(dnlink_time));
	pic_seq_model pic_seq_model_i (.clk(clk), .ord_valid(ord_valid), .ord_code(ord_code),
		.ord_addr(ord_addr), .instr_end(instr_end), .rupt_return(rupt_return),
		.dnlink_word_req(dnlink_word_req));

	// A 20 ns clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// The whole run needs at most about 8150 cycles; a hang is cut off well beyond that.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	function automatic logic [11:0] cnt_addr(input int c);
		cnt_addr = 12'h020 + 12'(c);
	endfunction

	function automatic logic [11:0] rupt_addr(input int i);
		rupt_addr = 12'h800 + 12'(4 * i);
	endfunction

	task automatic fail(input string msg);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask

	task automatic chk_vec(input logic [31:0] g, input logic [31:0] e, input string msg);
		tests_run++;
		if (g !== e) fail($sformatf("%s got %0h expected %0h", msg, g, e));
	endtask

	task automatic chk_rng(input int g, input int lo, input int hi, input string msg);
		tests_run++;
		if (g < lo || g > hi) fail($sformatf("%s count %0d", msg, g));
	endtask

	// Compares the collected order; with no order expected only its absence counts.
	task automatic chk_ord(input logic ev, input pic_pkg::pic_ord_t ec, input logic [11:0] ea);
		tests_run++;
		if (got !== ev || (ev && (code !== ec || addr !== ea)))
			fail($sformatf("order %0b %0d %0h expected %0b %0d %0h", got, code, addr, ev, ec, ea));
	endtask

	task automatic bnd(input logic ret);
		pic_seq_model_i.boundary(ret, got, code, addr);
	endtask

	// Raises one interrupt source for a single cycle.
	task automatic fire(input int i);
		if (i == 7) begin
			pic_seq_model_i.dn_req();
		end else begin
			@(negedge clk);
			key_press = (i == 4);
			mark_in = (i == 5);
			uplink_word_done = (i == 6);
			radar_word_done = (i == 8);
			hand_in_detent = (i != 9);
			@(negedge clk);
			{key_press, mark_in, uplink_word_done, radar_word_done} = 4'h0;
			hand_in_detent = 1'b1;
		end
	endtask

	task automatic inc(input int j);
		@(negedge clk);
		inc_pulse[j] = 1'b1;
		@(negedge clk);
		inc_pulse = '0;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence; the first basic period fires t6 and t5, and the run ends before the next t6.
	initial begin
		int j1, j2, n, g, cnt, ms, bad;
		logic prev;
		{rst_n, rupt_inhibit, uplink_bit, key_press, mark_in, radar_word_done} = 6'h00;
		{uplink_word_done, disc_we, burst_load, burst_num, burst_gap} = '0;
		{inc_pulse, key_code, disc_data} = '0;
		hand_in_detent = 1'b1;
		void'($urandom(94));
		repeat (5) @(negedge clk);
		chk_vec(32'(time_pulse), 32'h001, "reset time pulse");
		chk_vec(32'({ord_valid, in_rupt}), 32'h0, "reset order");
		rst_n = 1'b1;
		$display("test reset done");
		// The scaler starts at zero, so t6, t5, the real-time pulse and the second tick come at once.
		cnt = 0;
		repeat (60) begin
			@(negedge clk);
			if (dnlink_time_valid === 1'b1) begin
				cnt++;
				chk_vec(32'(dnlink_time), 32'h0, "first downlink time");
			end
		end
		chk_rng(cnt, 1, 1, "second ticks");
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(0));
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(0));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(1));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
		$display("test timers done");
		j1 = $urandom_range(0, 25);
		j2 = $urandom_range(j1 + 1, 26);
		@(negedge clk);
		inc_pulse[j1] = 1'b1;
		inc_pulse[j2] = 1'b1;
		inc(j2);
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j1 + 2));
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j2 + 2));
		bnd(0); chk_ord(0, pic_pkg::PIC_ORD_NONE, 12'h000);
		@(negedge clk);
		uplink_bit = 1'b1;
		@(negedge clk);
		uplink_bit = 1'b0;
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(1));
		$display("test counters done");
		for (int i = 4; i < 10; i++) begin
			key_code = 5'($urandom);
			fire(i);
			if (i == 4) chk_vec(32'(key_chan), 32'(key_code), "key channel");
			bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(i));
			chk_vec(32'(in_rupt), 32'h1, "in routine");
			bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
			chk_vec(32'(in_rupt), 32'h0, "back in program");
		end
		$display("test sources done");
		fire(8);
		fire(5);
		fire(4);
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(4));
		inc(j1);
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j1 + 2));
		chk_vec(32'(in_rupt), 32'h1, "routine kept");
		bnd(0); chk_ord(0, pic_pkg::PIC_ORD_NONE, 12'h000);
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(5));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(8));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
		fire(9);
		inc(j2);
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j2 + 2));
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(9));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
		rupt_inhibit = 1'b1;
		fire(6);
		bnd(0); chk_ord(0, pic_pkg::PIC_ORD_NONE, 12'h000);
		rupt_inhibit = 1'b0;
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(6));
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
		// A return that meets a counter grant is kept and resumes at the next free boundary.
		fire(5);
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RUPT, rupt_addr(5));
		inc(j2);
		bnd(1); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j2 + 2));
		chk_vec(32'(in_rupt), 32'h1, "return held over counter");
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_RESUME, 12'h000);
		chk_vec(32'(in_rupt), 32'h0, "held return resumed");
		$display("test priority done");
		// Two pulses on one counter with no boundary between them overrun it.
		@(negedge clk);
		inc_pulse[j1] = 1'b1;
		@(negedge clk);
		cnt = 0;
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			inc_pulse = '0;
			cnt += int'(count_alarm === 1'b1);
		end
		chk_rng(cnt, 1, 1, "alarm pulses");
		bnd(0); chk_ord(1, pic_pkg::PIC_ORD_COUNT, cnt_addr(j1 + 2));
		$display("test alarm done");
		for (int c = 0; c < 3; c++) begin
			n = $urandom_range(1, 4);
			g = $urandom_range(0, 3);
			@(negedge clk);
			burst_load = 3'(1 << c);
			burst_num = 15'(n);
			burst_gap = 10'(g);
			cnt = 0;
			@(negedge clk);
			burst_load = 3'h0;
			repeat (50 * (n * (g + 1) + 3)) begin
				@(negedge clk);
				cnt += int'(burst_out[c] === 1'b1);
			end
			chk_rng(cnt, n, n, "burst pulses");
		end
		disc_data = 16'($urandom);
		@(negedge clk);
		disc_we = 1'b1;
		@(negedge clk);
		disc_we = 1'b0;
		@(negedge clk);
		chk_vec(32'(disc_out), 32'(disc_data), "discrete out");
		$display("test outputs done");
		// 5000 cycles hold 102.4 basic periods and 8.53 memory cycles.
		{cnt, ms, bad} = '0;
		prev = sync_out;
		repeat (5000) begin
			@(negedge clk);
			cnt += int'(sync_out === 1'b1 && prev === 1'b0);
			prev = sync_out;
			ms += int'(mem_cycle_start === 1'b1);
			bad += int'(!$onehot(time_pulse));
		end
		chk_rng(cnt, 102, 103, "sync rises");
		chk_rng(ms, 8, 9, "memory cycles");
		chk_rng(bad, 0, 0, "time pulse not one-hot");
		$display("test timing done");
		end_of_test();
	end
endmodule // testbench
